/* File: swr_cpu_model.sv */
// Purpose: Processor model that services the watchdog and sees reset.
// Assumes: The bench sets the kick period and releases the kick driver.
// Notes: A released kick wire wanders every cycle, since nothing pulls it.
`timescale 1ns/100ps
`default_nettype none
module swr_cpu_model (
    input wire logic clk_in, // System clock.
    input wire logic reset_line_n_in, // Reset line level at the processor.
    input wire logic run_in, // High while software services the timer.
    input wire logic release_in, // High while the kick driver is off.
    input wire logic [31:0] period_in, // Cycles between kick edges.
    output logic kick_out, // Level on the kick wire.
    output logic float_out // Comparator view: kick wire undriven.
);
    // ==========================================================
    // Kick generator
    // ==========================================================
    logic level = 1'b0; // Level the processor drives.
    logic wander = 1'b0; // Undriven wire, changes every cycle.
    logic [31:0] cnt = 32'h0; // Cycles since the last kick edge.

    // A processor held in reset runs no code, so it cannot kick.
    always @(negedge clk_in) begin
        wander <= ~wander;
        if (!reset_line_n_in || !run_in) begin
            cnt <= 32'h0;
        end else if (cnt + 32'h1 >= period_in) begin
            cnt <= 32'h0;
            level <= ~level;
        end else begin
            cnt <= cnt + 32'h1;
        end
    end

    // The wandering level must not be taken for a stream of kicks.
    assign kick_out = release_in ? wander : level;
    assign float_out = release_in;
endmodule
`default_nettype wire

/* File: swr_pkg.sv */
// Purpose: Shared constants and types for the supervisory reset block.
// Assumes: A 200 MHz clock and a 10 us internal timebase tick.
// Notes: Times keep their printed figures; cycle counts derive from them.
package swr_pkg;
    // ==========================================================
    // Clock and timebase
    // ==========================================================
    localparam int CLK_NS = 5; // Clock period in ns.
    localparam int TICK_US = 10; // Prescaled timebase period in us.
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_NS; // 2000 cycles.
    localparam int PRE_W = 11; // Prescaler counter width.
    // Manual reset glitch filter time, rounded up to whole cycles.
    localparam int GLITCH_NS = 100;
    localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int MR_W = 5; // Glitch filter counter width.

    // ==========================================================
    // Watchdog periods, typical figures, rounded down to ticks
    // ==========================================================
    localparam int WD0_US = 6300;
    localparam int WD1_US = 102000;
    localparam int WD2_US = 1600000;
    localparam int WD3_US = 25600000;
    localparam int WD0_TICKS = WD0_US / TICK_US;
    localparam int WD1_TICKS = WD1_US / TICK_US;
    localparam int WD2_TICKS = WD2_US / TICK_US;
    localparam int WD3_TICKS = WD3_US / TICK_US;
    localparam int WD_W = 22; // Watchdog counter width.

    // ==========================================================
    // Reset hold periods, least figures, rounded up to ticks
    // ==========================================================
    localparam int HOLD0_US = 1000;
    localparam int HOLD1_US = 20000;
    localparam int HOLD2_US = 140000;
    localparam int HOLD3_US = 1120000;
    localparam int HOLD0_TICKS = (HOLD0_US + TICK_US - 1) / TICK_US;
    localparam int HOLD1_TICKS = (HOLD1_US + TICK_US - 1) / TICK_US;
    localparam int HOLD2_TICKS = (HOLD2_US + TICK_US - 1) / TICK_US;
    localparam int HOLD3_TICKS = (HOLD3_US + TICK_US - 1) / TICK_US;
    localparam int HOLD_W = 17; // Hold counter width.

    // ==========================================================
    // Synchroniser bundle layout and values after reset
    // ==========================================================
    localparam int SY_W = 8; // Bundle width.
    localparam int SY_SUPPLY = 0; // Supply below threshold.
    localparam int SY_MR_N = 1; // Manual reset, active low.
    localparam int SY_KICK = 2; // Watchdog kick level.
    localparam int SY_FLOAT = 3; // Kick pin seen floating.
    localparam int SY_WDSEL = 4; // Two bits of watchdog select.
    localparam int SY_HOLDSEL = 6; // Two bits of hold select.
    localparam logic [SY_W-1:0] SY_RESET = 8'h02; // Manual reset idle.

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [0:0] {ST_HOLD, ST_RUN} swr_state_t;

    typedef struct packed {
        logic [SY_W-1:0] ff1; // First stage, read by ff2 only.
        logic [SY_W-1:0] ff2; // Second stage.
        logic [SY_W-1:0] ff3; // Third stage.
        logic [SY_W-1:0] clean; // Accepted level.
    } swr_sync_t;

    typedef struct packed {
        swr_state_t st; // Holding reset or running.
        logic [PRE_W-1:0] pre_cnt; // Prescaler.
        logic tick; // One-cycle timebase pulse.
        logic [MR_W-1:0] mr_cnt; // Manual reset low time.
        logic mr_act; // Manual reset accepted.
        logic kick_prev; // Previous kick sample.
        logic [WD_W-1:0] wd_cnt; // Watchdog ticks since last clear.
        logic [HOLD_W-1:0] hold_cnt; // Ticks of reset hold.
        logic reset_n; // Active-low output level.
        logic reset_n_oe; // Active-low output enable.
        logic reset_hi; // Active-high output.
    } swr_core_t;
endpackage

/* File: swr_supervisor.sv */
// Purpose: Supervisory reset generator with manual reset and watchdog.
// Assumes: Supply comparator, float detector and selects arrive as pins.
// Notes: Reset holds for the selected period after every cause clears.
`timescale 1ns/100ps
`default_nettype none
module swr_supervisor #(
    parameter bit OPEN_DRAIN = 1'b0, // Variant: open-drain active-low.
    parameter int WD0 = swr_pkg::WD0_TICKS, // Watchdog option 0, ticks.
    parameter int WD1 = swr_pkg::WD1_TICKS, // Watchdog option 1, ticks.
    parameter int WD2 = swr_pkg::WD2_TICKS, // Watchdog option 2, ticks.
    parameter int WD3 = swr_pkg::WD3_TICKS, // Watchdog option 3, ticks.
    parameter int HOLD0 = swr_pkg::HOLD0_TICKS, // Hold option 0, ticks.
    parameter int HOLD1 = swr_pkg::HOLD1_TICKS, // Hold option 1, ticks.
    parameter int HOLD2 = swr_pkg::HOLD2_TICKS, // Hold option 2, ticks.
    parameter int HOLD3 = swr_pkg::HOLD3_TICKS // Hold option 3, ticks.
) (
    input wire logic clk_in, // System clock, 200 MHz.
    input wire logic reset_in, // Synchronous reset, active high.
    input wire logic clk_en_in, // Clock enable; low freezes state.
    input wire logic supply_low_in, // Supply below supply_threshold.
    input wire logic manual_reset_n_in, // Manual reset, active low.
    input wire logic watchdog_kick_in, // Watchdog kick level.
    input wire logic kick_float_in, // Kick pin seen undriven.
    input wire logic [1:0] wd_sel_in, // Watchdog period select.
    input wire logic [1:0] hold_sel_in, // Reset hold time select.
    output logic reset_n_out, // Active-low reset level.
    output logic reset_n_oe_out, // Drive enable for active-low reset.
    output logic reset_out // Active-high reset.
);
    swr_pkg::swr_core_t s; // Registered state.
    swr_pkg::swr_core_t next_s; // Next state.
    swr_sync_if sy (); // Pin bundle to the synchroniser.
    logic sup_low; // Clean supply-low level.
    logic mr_low; // Clean manual reset, low level.
    logic kick; // Clean kick level.
    logic wd_off; // Watchdog disabled by a floating kick pin.
    logic kick_edge; // Kick changed since the last sample.
    logic [swr_pkg::WD_W-1:0] wd_lim; // Selected watchdog period.
    logic [swr_pkg::HOLD_W-1:0] hold_lim; // Selected hold period.
    logic cause; // Supply or manual reset active now.

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Every pin passes three stages before the core sees it.
    assign sy.raw = {hold_sel_in, wd_sel_in, kick_float_in,
        watchdog_kick_in, manual_reset_n_in, supply_low_in};

    swr_sync3 u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .sy(sy)
    );

    assign sup_low = sy.clean[swr_pkg::SY_SUPPLY];
    assign mr_low = !sy.clean[swr_pkg::SY_MR_N];
    assign kick = sy.clean[swr_pkg::SY_KICK];
    assign wd_off = sy.clean[swr_pkg::SY_FLOAT];
    assign kick_edge = kick != s.kick_prev;
    assign cause = sup_low || s.mr_act;

    // ==========================================================
    // Period selection
    // ==========================================================
    // The selects are straps, but a change simply takes effect at once.
    always_comb begin
        case (sy.clean[swr_pkg::SY_WDSEL +: 2])
            2'h0: wd_lim = swr_pkg::WD_W'(WD0);
            2'h1: wd_lim = swr_pkg::WD_W'(WD1);
            2'h2: wd_lim = swr_pkg::WD_W'(WD2);
            default: wd_lim = swr_pkg::WD_W'(WD3);
        endcase
        case (sy.clean[swr_pkg::SY_HOLDSEL +: 2])
            2'h0: hold_lim = swr_pkg::HOLD_W'(HOLD0);
            2'h1: hold_lim = swr_pkg::HOLD_W'(HOLD1);
            2'h2: hold_lim = swr_pkg::HOLD_W'(HOLD2);
            default: hold_lim = swr_pkg::HOLD_W'(HOLD3);
        endcase
    end

    // ==========================================================
    // Core next state
    // ==========================================================
    // One process computes the whole next state, outputs included,
    // so every output comes straight from a flip-flop.
    always_comb begin
        next_s = s;
        next_s.kick_prev = kick;
        // Prescaler gives one tick every TICK_CYCLES cycles.
        next_s.tick = 1'b0;
        if (s.pre_cnt == swr_pkg::PRE_W'(swr_pkg::TICK_CYCLES - 1)) begin
            next_s.pre_cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.pre_cnt = s.pre_cnt + 1'b1;
        end
        // Short low pulses never reach the count, so they are ignored.
        if (!mr_low) begin
            next_s.mr_cnt = '0;
            next_s.mr_act = 1'b0;
        end else if (s.mr_cnt ==
                     swr_pkg::MR_W'(swr_pkg::GLITCH_CYCLES)) begin
            next_s.mr_act = 1'b1;
        end else begin
            next_s.mr_cnt = s.mr_cnt + 1'b1;
        end
        case (s.st)
            swr_pkg::ST_HOLD: begin
                // Watchdog stays cleared for the whole reset.
                next_s.wd_cnt = '0;
                if (cause) begin
                    next_s.hold_cnt = '0;
                end else if (s.hold_cnt >= hold_lim) begin
                    next_s.st = swr_pkg::ST_RUN;
                end else if (s.tick) begin
                    next_s.hold_cnt = s.hold_cnt + 1'b1;
                end
            end
            swr_pkg::ST_RUN: begin
                next_s.hold_cnt = '0;
                if (cause) begin
                    next_s.st = swr_pkg::ST_HOLD;
                    next_s.wd_cnt = '0;
                end else if (wd_off || kick_edge) begin
                    next_s.wd_cnt = '0;
                end else if (s.wd_cnt >= wd_lim) begin
                    next_s.st = swr_pkg::ST_HOLD;
                    next_s.wd_cnt = '0;
                end else if (s.tick) begin
                    next_s.wd_cnt = s.wd_cnt + 1'b1;
                end
            end
            default: begin
                next_s.st = swr_pkg::ST_HOLD;
            end
        endcase
        // Both outputs follow the next state together.
        next_s.reset_hi = next_s.st == swr_pkg::ST_HOLD;
        if (OPEN_DRAIN) begin
            next_s.reset_n = 1'b0;
            next_s.reset_n_oe = next_s.reset_hi;
        end else begin
            next_s.reset_n = !next_s.reset_hi;
            next_s.reset_n_oe = 1'b1;
        end
    end

    // Register the state; reset starts a full power-on hold period.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= '0;
            s.st <= swr_pkg::ST_HOLD;
            s.reset_hi <= 1'b1;
            s.reset_n_oe <= 1'b1;
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    assign reset_n_out = s.reset_n;
    assign reset_n_oe_out = s.reset_n_oe;
    assign reset_out = s.reset_hi;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in || !clk_en_in);

    sequence mr_held_low;
        mr_low [*8];
    endsequence

    a_supply_asserts: assert property (
        sup_low |=> s.reset_hi)
        else $error("Supply low did not assert reset.");
    a_mr_glitch_filter: assert property (
        $rose(s.mr_act) |-> $past(mr_low, 20) && $past(mr_low))
        else $error("Manual reset accepted too early.");
    // A low that has only just begun must not be taken as a reset yet.
    a_mr_short_ignored: assert property (
        $rose(mr_low) ##1 mr_held_low |-> !s.mr_act)
        else $error("Manual reset accepted inside the filter time.");
    a_wd_expiry_reset: assert property (
        s.st == swr_pkg::ST_RUN && !cause && !wd_off && !kick_edge
        && s.wd_cnt >= wd_lim |=> s.reset_hi)
        else $error("Watchdog expiry did not assert reset.");
    a_kick_clears_wd: assert property (
        s.st == swr_pkg::ST_RUN && kick_edge |=> s.wd_cnt == 0)
        else $error("Kick edge did not clear watchdog.");
    a_reset_clears_wd: assert property (
        s.reset_hi |-> s.wd_cnt == 0)
        else $error("Watchdog counted during reset.");
    a_float_disables_wd: assert property (
        wd_off && s.st == swr_pkg::ST_RUN |=> s.wd_cnt == 0 && (sup_low
        || $past(s.mr_act) || !s.reset_hi || $past(cause)))
        else $error("Floating kick did not disable watchdog.");
    // The active-high pin is the inverse of the level on the low line.
    a_dual_outputs_match: assert property (
        reset_out != (reset_n_oe_out ? reset_n_out : 1'b1))
        else $error("Active-high output disagrees with active-low line.");
    a_low_output_drive: assert property (
        OPEN_DRAIN ? (!s.reset_n && s.reset_n_oe == s.reset_hi)
        : (s.reset_n_oe && s.reset_n != s.reset_hi))
        else $error("Active-low output drive is wrong.");
    a_hold_before_release: assert property (
        $fell(s.reset_hi) |-> $past(s.hold_cnt) >= $past(hold_lim))
        else $error("Reset released before hold period.");
    a_wd_stays_cleared: assert property (
        s.st == swr_pkg::ST_HOLD ##1 s.st == swr_pkg::ST_RUN
        |-> s.wd_cnt == 0)
        else $error("Watchdog not cleared at reset release.");
endmodule
`default_nettype wire

/* File: swr_supervisor_bench.sv */
// Purpose: Self-checking bench for the supervisory reset block.
// Assumes: Shortened tick counts; both output variants run side by side.
// Notes: Times are measured in cycles at falling edges, in ranges of a tick.
`timescale 1ns/100ps
`default_nettype none
module swr_supervisor_bench;
    // ==========================================================
    // Settings and wiring
    // ==========================================================
    localparam int T = swr_pkg::TICK_CYCLES; // Cycles per tick.
    localparam int WDT [4] = '{2, 3, 4, 5}; // Watchdog limits, ticks.
    localparam int HLD [4] = '{2, 2, 3, 3}; // Hold limits, ticks.
    logic clk_in = 1'b0; // System clock.
    logic reset_in = 1'b1; // Bench reset.
    logic supply_low = 1'b0; // Supply comparator pin.
    logic mr_n = 1'b1; // Manual reset pin.
    logic [1:0] wd_sel = 2'h0; // Watchdog period select.
    logic [1:0] hold_sel = 2'h0; // Hold time select.
    logic run = 1'b1; // Processor services the timer.
    logic rel = 1'b0; // Processor releases the kick wire.
    logic clk_en = 1'b1; // Clock enable shared by both variants.
    logic kick; // Kick wire.
    logic kick_float; // Kick wire undriven.
    wire logic [1:0] rn; // Active-low levels, push-pull then open-drain.
    wire logic [1:0] roe; // Their drive enables.
    wire logic [1:0] rhi; // Active-high outputs.
    int errors = 0; // Mismatches.
    int n_tests = 0; // Comparisons.
    // Undriven line is pulled high.
    wire logic [1:0] line_n = ~roe | rn;

    always #2.5 clk_in = ~clk_in;

    // Index 0 is push-pull, index 1 open-drain; inputs are shared.
    for (genvar g = 0; g < 2; g++) begin : v
        swr_supervisor #(.OPEN_DRAIN(g == 1), .WD0(WDT[0]), .WD1(WDT[1]),
            .WD2(WDT[2]), .WD3(WDT[3]), .HOLD0(HLD[0]), .HOLD1(HLD[1]),
            .HOLD2(HLD[2]), .HOLD3(HLD[3])) uut (
            .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en),
            .supply_low_in(supply_low), .manual_reset_n_in(mr_n),
            .watchdog_kick_in(kick), .kick_float_in(kick_float),
            .wd_sel_in(wd_sel), .hold_sel_in(hold_sel),
            .reset_n_out(rn[g]), .reset_n_oe_out(roe[g]),
            .reset_out(rhi[g]));
    end

    swr_cpu_model cpu (.clk_in(clk_in), .reset_line_n_in(line_n[0]),
        .run_in(run), .release_in(rel), .period_in(32'(T / 2)),
        .kick_out(kick), .float_out(kick_float));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // A cycle count is judged against a window, so tick phase is allowed.
    task automatic in_span(input string what, input int n, input int lo,
                           input int hi);
        check(what, 32'(n >= lo && n <= hi), 32'h1);
    endtask

    // Counts falling edges until the active-high output shows lvl.
    task automatic wait_out(input logic lvl, input int max, output int n);
        n = 0;
        while (rhi[0] !== lvl && n < max) begin
            @(negedge clk_in);
            n++;
        end
    endtask

    // Both variants must agree on every pin.
    task automatic pins(input logic act);
        check("reset_hi", {31'h0, rhi[0]}, {31'h0, act});
        check("od_hi", {31'h0, rhi[1]}, {31'h0, act});
        check("line_pp", {31'h0, line_n[0]}, {31'h0, ~act});
        check("line_od", {31'h0, line_n[1]}, {31'h0, ~act});
        check("od_level", {31'h0, rn[1]}, 32'h0);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_power_on();
        int n;
        pins(1'b1);
        reset_in = 1'b0;
        wait_out(1'b0, 4 * T, n);
        in_span("power_on_hold", n, T, 3 * T + 20);
        pins(1'b0);
    endtask

    // Held longer than the hold, so a one-shot hold would show up.
    // The supply first falls while the clock enable is low, so nothing
    // may move until the enable returns.
    task automatic t_supply();
        int n;
        clk_en = 1'b0;
        supply_low = 1'b1;
        wait_out(1'b1, 20, n);
        in_span("supply_frozen", n, 20, 20);
        clk_en = 1'b1;
        wait_out(1'b1, 20, n);
        in_span("supply_assert", n, 1, 10);
        repeat (2 * T) @(negedge clk_in);
        pins(1'b1);
        supply_low = 1'b0;
        wait_out(1'b0, 4 * T, n);
        in_span("supply_hold", n, T, 3 * T + 20);
    endtask

    task automatic t_manual();
        int n;
        mr_n = 1'b0;
        repeat (15) @(negedge clk_in);
        mr_n = 1'b1;
        wait_out(1'b1, 60, n);
        in_span("mr_glitch", n, 60, 60);
        mr_n = 1'b0;
        wait_out(1'b1, 60, n);
        in_span("mr_accept", n, 20, 30);
        repeat (20) @(negedge clk_in);
        pins(1'b1);
        mr_n = 1'b1;
        wait_out(1'b0, 4 * T, n);
        in_span("mr_hold", n, T, 3 * T + 20);
    endtask

    // Kicks come every half tick, well inside the shortest period.
    task automatic t_kicks();
        int n;
        wait_out(1'b1, 3 * T, n);
        in_span("kicks_hold_off", n, 3 * T, 3 * T);
    endtask

    // The count starts at the last kick, so the stop follows one.
    task automatic t_expire(input int sel);
        int n;
        wd_sel = 2'(sel);
        hold_sel = 2'(sel);
        @(kick);
        @(negedge clk_in);
        run = 1'b0;
        wait_out(1'b1, (WDT[sel] + 2) * T, n);
        in_span("wd_expire", n, (WDT[sel] - 1) * T,
                WDT[sel] * T + 20);
        wait_out(1'b0, (HLD[sel] + 2) * T, n);
        in_span("hold_select", n, (HLD[sel] - 1) * T,
                (HLD[sel] + 1) * T + 20);
        if (sel == 0) begin
            wait_out(1'b1, (WDT[0] + 2) * T, n);
            in_span("wd_from_release", n, (WDT[0] - 1) * T,
                    WDT[0] * T + 20);
            wait_out(1'b0, (HLD[0] + 2) * T, n);
            in_span("hold_again", n, (HLD[0] - 1) * T,
                    (HLD[0] + 1) * T + 20);
        end
        run = 1'b1;
    endtask

    task automatic t_float();
        int n;
        wd_sel = 2'h0;
        rel = 1'b1;
        wait_out(1'b1, 3 * T, n);
        in_span("float_no_reset", n, 3 * T, 3 * T);
        rel = 1'b0;
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        repeat (16) @(negedge clk_in);
        t_power_on();
        t_supply();
        t_manual();
        t_kicks();
        for (int s = 0; s < 4; s++) begin
            t_expire(s);
        end
        t_float();
        report_and_stop();
    end

    // Some margin over the at most 45 ticks that the sequence takes.
    initial begin
        repeat (48 * T) @(posedge clk_in);
        errors++;
        $display("run did not finish in time");
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: swr_sync3.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs arrive from outside the clock domain.
// Notes: A change is accepted once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module swr_sync3 (
    input wire logic clk_in, // System clock.
    input wire logic reset_in, // Synchronous reset, active high.
    input wire logic clk_en_in, // Clock enable; low freezes state.
    swr_sync_if.sync_mp sy // Raw levels in, clean levels out.
);
    swr_pkg::swr_sync_t s; // Registered state.
    swr_pkg::swr_sync_t next_s; // Next state.

    // ==========================================================
    // Next state
    // ==========================================================
    // Only the second stage reads the first, so metastability stays put.
    always_comb begin
        next_s = s;
        next_s.ff1 = sy.raw;
        next_s.ff2 = s.ff1;
        next_s.ff3 = s.ff2;
        // Each bit moves only where stages two and three agree.
        next_s.clean = (s.ff2 & s.ff3) | (s.clean & (s.ff2 ^ s.ff3));
    end

    // Register the whole state; reset loads constants only.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s <= {4{swr_pkg::SY_RESET}};
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    assign sy.clean = s.clean;
endmodule
`default_nettype wire

/* File: swr_sync_if.sv */
// Purpose: Carries raw pin levels into the synchroniser and clean back.
// Assumes: One clock domain on the clean side.
// Notes: Plain wires only; no timing of its own.
`timescale 1ns/100ps
`default_nettype none
interface swr_sync_if;
    logic [swr_pkg::SY_W-1:0] raw; // Asynchronous pin levels.
    logic [swr_pkg::SY_W-1:0] clean; // Filtered, synchronous levels.
    modport src_mp (output raw, input clean);
    modport sync_mp (input raw, output clean);
endinterface
`default_nettype wire
